// *** core/src_pkg.sv ***
`default_nettype none
package src_pkg;
  // ****************************************
  // clock and rate selection
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int SEL_W = 3;
  localparam int DIV_W = 16;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  // ****************************************
  // command grammar
  // ****************************************
  localparam logic [7:0] CH_WRITE = 8'h21;
  localparam logic [7:0] CH_READ = 8'h40;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UF = 8'h46;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LF = 8'h66;
  localparam logic [7:0] CH_HEX_OFS = 8'h37;
  localparam logic [1:0] LAST_NIB = 2'h3;
  localparam int WORD_W = 16;
  localparam int NUM_REGS = 16;
  localparam int LED_W = 4;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [WORD_W-1:0] TOP_ADDR = 16'h000F;
  typedef enum logic [1:0] {
    ST_ADDR = 2'b00,
    ST_OP = 2'b01,
    ST_DATA = 2'b10,
    ST_SEND = 2'b11
  } src_state_e;
  // one received character from the serial receiver
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } src_char_s;
  // bit rate for each selector code
  function automatic int unsigned src_baud(input logic [SEL_W-1:0] sel);
    case (sel)
      3'h0: return 115200;
      3'h1: return 57600;
      3'h2: return 38400;
      3'h3: return 19200;
      3'h4: return 9600;
      3'h5: return 4800;
      3'h6: return 2400;
      default: return 1200;
    endcase
  endfunction
  // clocks per 16x tick, rounded to nearest
  function automatic logic [DIV_W-1:0] src_div(input logic [SEL_W-1:0] sel);
    int unsigned d;
    d = (CLK_HZ + (OVERSAMPLE * src_baud(sel)) / 2) / (OVERSAMPLE * src_baud(sel));
    return d[DIV_W-1:0];
  endfunction
endpackage
`default_nettype wire

// *** core/src_top.sv ***
// What this block does
// (R1) rate selector codes 000..111 pick 115200 down to 1200 bit/s
// (R2) selector changes take effect only through a reset
// (R3) terminal must run at the same bit rate as selected
// (R4) reduced build forces selector msb to zero, four rates remain
// (R5) command is address then '!' plus data, or '@' alone
// (R6) address and data are four hex characters each, 16 bits
// (R7) write stores data at addressed register, sends nothing back
// (R8) read returns last written value as four hex characters
// (R9) register bank decodes addresses 0x0000 to 0x000F
// (R10) indicators show last written value until the next write
// (R11) indicators take the low four bits of each written word
// (R12) 8N1 characters; bad characters drop back to waiting for address
// (R13) reset clears registers, indicators, and idles the parser
`default_nettype none
module src_top
  import src_pkg::*;
#(
  parameter bit REDUCED_SEL = 1'b0
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // rate selection
  input wire logic [SEL_W-1:0] RATE_SEL_I,
  output logic [SEL_W-1:0] RATE_CODE_O,
  output logic [DIV_W-1:0] BAUD_DIV_O,
  // characters from the receiver
  input wire src_char_s RX_CHAR_I,
  // characters to the transmitter
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  // indicators
  output logic [LED_W-1:0] LED_O
);
  // ****************************************
  // character decode
  // ****************************************
  src_state_e state;
  logic [1:0] nib_cnt;
  logic [WORD_W-1:0] addr;
  logic [WORD_W-1:0] wdata;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] regs [NUM_REGS];
  wire logic [7:0] ch = RX_CHAR_I.data;
  wire logic ch_v = RX_CHAR_I.valid;
  wire logic is_dig = (ch >= CH_0) && (ch <= CH_9);
  wire logic is_up = (ch >= CH_UA) && (ch <= CH_UF);
  wire logic is_lo = (ch >= CH_LA) && (ch <= CH_LF);
  wire logic is_hex = is_dig || is_up || is_lo;
  wire logic [7:0] nib_sub = is_dig ? CH_0 : (is_up ? CH_UA : CH_LA);
  wire logic [7:0] nib_off = ch - nib_sub;
  wire logic [3:0] nib = is_dig ? nib_off[3:0] : nib_off[3:0] + 4'hA;
  wire logic hex_in = ch_v && is_hex;
  wire logic last_nib = nib_cnt == LAST_NIB;
  wire logic [WORD_W-1:0] next_addr = {addr[WORD_W-5:0], nib};
  wire logic [WORD_W-1:0] next_wdata = {wdata[WORD_W-5:0], nib};
  wire logic addr_ok = addr <= TOP_ADDR; // R9
  wire logic do_write = (state == ST_DATA) && hex_in && last_nib && addr_ok; // R7
  wire logic do_read = (state == ST_OP) && ch_v && (ch == CH_READ); // R5
  wire logic tx_take = TX_VALID_O && TX_READY_I;
  wire logic [3:0] out_nib = rd_word[WORD_W-1:WORD_W-4];
  wire logic [7:0] out_ch = (out_nib < 4'hA) ? CH_0 + {4'h0, out_nib}
                                             : CH_HEX_OFS + {4'h0, out_nib};
  wire logic [SEL_W-1:0] sel_eff = REDUCED_SEL ? {1'b0, RATE_SEL_I[SEL_W-2:0]} : RATE_SEL_I;
  // ****************************************
  // rate selection
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      RATE_CODE_O <= sel_eff; // R2 R4
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      BAUD_DIV_O <= src_div(sel_eff); // R1
    end
  end
  // ****************************************
  // command parser
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      state <= ST_ADDR; // R13
      nib_cnt <= 2'h0;
      addr <= WORD_RST;
      wdata <= WORD_RST;
    end else begin
      case (state)
        ST_ADDR: begin
          if (hex_in) begin // R6
            addr <= next_addr;
            nib_cnt <= nib_cnt + 2'h1;
            if (last_nib) begin
              state <= ST_OP;
            end
          end else if (ch_v) begin
            nib_cnt <= 2'h0; // R12
          end
        end
        ST_OP: begin
          nib_cnt <= 2'h0;
          if (ch_v && ch == CH_WRITE) begin
            state <= ST_DATA; // R5
          end else if (do_read) begin
            state <= ST_SEND; // R8
          end else if (ch_v) begin
            state <= ST_ADDR; // R12
          end
        end
        ST_DATA: begin
          if (hex_in) begin // R6
            wdata <= next_wdata;
            nib_cnt <= nib_cnt + 2'h1;
            if (last_nib) begin
              state <= ST_ADDR;
            end
          end else if (ch_v) begin
            nib_cnt <= 2'h0;
            state <= ST_ADDR; // R12
          end
        end
        ST_SEND: begin
          if (tx_take) begin
            nib_cnt <= nib_cnt + 2'h1;
            if (last_nib) begin
              state <= ST_ADDR;
            end
          end
        end
        default: state <= ST_ADDR;
      endcase
    end
  end
  // ****************************************
  // register bank and indicators
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
          regs[gi] <= WORD_RST; // R13
        end else if (do_write && addr[3:0] == gi) begin
          regs[gi] <= next_wdata; // R7
        end
      end
    end
  endgenerate
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      LED_O <= '0; // R13
    end else if (do_write) begin
      LED_O <= next_wdata[LED_W-1:0]; // R10 R11
    end
  end
  // ****************************************
  // read reply
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rd_word <= WORD_RST;
      TX_VALID_O <= 1'b0;
      TX_DATA_O <= 8'h00;
    end else if (do_read) begin
      rd_word <= addr_ok ? regs[addr[3:0]] : WORD_RST; // R8 R9
      TX_VALID_O <= 1'b0;
    end else if (state == ST_SEND) begin
      if (!TX_VALID_O) begin
        TX_DATA_O <= out_ch; // R8
        TX_VALID_O <= 1'b1;
        rd_word <= {rd_word[WORD_W-5:0], 4'h0};
      end else if (tx_take) begin
        TX_VALID_O <= 1'b0;
      end
    end else begin
      TX_VALID_O <= 1'b0;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  sequence s_write_char;
    state == ST_DATA && hex_in && last_nib && addr_ok;
  endsequence
  sequence s_read_char;
    state == ST_OP && ch_v && ch == CH_READ;
  endsequence
  property p_rate_table;
    @(posedge REF_CLK_I) disable iff (RESET_I)
      BAUD_DIV_O == src_div(RATE_CODE_O);
  endproperty
  a_rate_table: assert property (p_rate_table) else $error("divisor mismatches code"); // R1
  property p_reduced;
    @(posedge REF_CLK_I) disable iff (RESET_I)
      REDUCED_SEL |-> !RATE_CODE_O[SEL_W-1];
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced build msb set"); // R4
  property p_rate_hold;
    @(posedge REF_CLK_I) !RESET_I && !$past(RESET_I) |-> $stable(RATE_CODE_O);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate changed without reset"); // R2
  property p_write;
    @(posedge REF_CLK_I) disable iff (RESET_I)
      s_write_char |=> regs[$past(addr[3:0])] == $past(next_wdata) && state == ST_ADDR
        && !TX_VALID_O;
  endproperty
  a_write: assert property (p_write) else $error("write not stored"); // R7
  property p_led;
    @(posedge REF_CLK_I) disable iff (RESET_I)
      s_write_char |=> LED_O == $past(next_wdata[LED_W-1:0]);
  endproperty
  a_led: assert property (p_led) else $error("indicators not updated"); // R11
  property p_led_hold;
    @(posedge REF_CLK_I) disable iff (RESET_I)
      !do_write |=> $stable(LED_O);
  endproperty
  a_led_hold: assert property (p_led_hold) else $error("indicators moved without write"); // R10
  property p_read;
    @(posedge REF_CLK_I) disable iff (RESET_I)
      s_read_char |=> state == ST_SEND ##1 TX_VALID_O;
  endproperty
  a_read: assert property (p_read) else $error("read reply not started"); // R8
  property p_bad_char;
    @(posedge REF_CLK_I) disable iff (RESET_I)
      state == ST_OP && ch_v && ch != CH_READ && ch != CH_WRITE |=> state == ST_ADDR
        && nib_cnt == 2'h0;
  endproperty
  a_bad_char: assert property (p_bad_char) else $error("bad operator not dropped"); // R12
  property p_reset;
    @(posedge REF_CLK_I) RESET_I |=> state == ST_ADDR && LED_O == '0 && !TX_VALID_O;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong"); // R13
  property p_addr_done;
    @(posedge REF_CLK_I) disable iff (RESET_I)
      state == ST_ADDR && hex_in && last_nib |=> state == ST_OP;
  endproperty
  a_addr_done: assert property (p_addr_done) else $error("four address digits not taken"); // R6
endmodule
`default_nettype wire

// *** tb/src_tx_model.sv ***
`default_nettype none
// ****************************************
// serial transmitter side: takes reply characters, stalls at random
// ****************************************
module src_tx_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // characters offered by the interpreter
  input wire logic [7:0] data_i,
  input wire logic valid_i,
  output logic ready_o,
  // characters taken, one pulse each
  output logic got_o,
  output logic [7:0] got_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  integer seed = 12;
  // one process owns every output of the model
  initial begin
    ready_o = 1'b0;
    got_o = 1'b0;
    got_data_o = 8'h00;
    forever begin
      @(posedge clk_i);
      got_o <= valid_i && ready_o && !rst_i;
      got_data_o <= data_i;
      #10 ready_o = ($random(seed) % 3) == 0;
    end
  end
endmodule
`default_nettype wire

// *** tb/test_src_top.sv ***
`default_nettype none
module test_src_top
  import src_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK_I = 1'b0, RESET_I = 1'b1;
  logic [SEL_W-1:0] RATE_SEL_I = 3'h0;
  src_char_s RX_CHAR_I = '0;
  logic [SEL_W-1:0] code, rcode;
  logic [DIV_W-1:0] div, rdiv;
  logic [7:0] tx_data;
  logic tx_valid, tx_ready, got;
  logic [7:0] got_data;
  logic [LED_W-1:0] led;
  logic [7:0] rxq[$];
  logic [15:0] d[16];
  integer mismatches = 0, checks = 0, seed;
  src_top dut (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .RATE_SEL_I(RATE_SEL_I),
    .RATE_CODE_O(code), .BAUD_DIV_O(div), .RX_CHAR_I(RX_CHAR_I), .TX_DATA_O(tx_data),
    .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .LED_O(led));
  src_top #(.REDUCED_SEL(1'b1)) dut_red (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
    .RATE_SEL_I(RATE_SEL_I), .RATE_CODE_O(rcode), .BAUD_DIV_O(rdiv), .RX_CHAR_I(RX_CHAR_I),
    .TX_DATA_O(), .TX_VALID_O(), .TX_READY_I(1'b1), .LED_O());
  src_tx_model tx (.clk_i(REF_CLK_I), .rst_i(RESET_I), .data_i(tx_data), .valid_i(tx_valid),
    .ready_o(tx_ready), .got_o(got), .got_data_o(got_data));
  initial begin
    forever #50 REF_CLK_I = ~REF_CLK_I;
  end
  always @(posedge REF_CLK_I) begin
    if (got === 1'b1) rxq.push_back(got_data);
  end
  // ****************************************
  // expectations and compares
  // ****************************************
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  function automatic logic [15:0] dv(input logic [2:0] s);
    logic [15:0] t[8] = '{16'h0005, 16'h000B, 16'h0010, 16'h0021,
                          16'h0041, 16'h0082, 16'h0104, 16'h0209};
    return t[s];
  endfunction
  task automatic bad(input logic [18:0] g, input logic [18:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_char(input logic [7:0] g, input logic [7:0] e);
    bad({11'h000, g}, {11'h000, e});
  endtask
  task automatic cmp_led(input logic [3:0] g, input logic [3:0] e);
    bad({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic cmp_rate(input logic [18:0] g, input logic [18:0] e);
    bad(g, e);
  endtask
  // ****************************************
  // character traffic
  // ****************************************
  task automatic send(input logic [7:0] c);
    @(posedge REF_CLK_I);
    #10 RX_CHAR_I = {1'b1, c};
    @(posedge REF_CLK_I);
    #10 RX_CHAR_I = '0;
  endtask
  task automatic send_word(input logic [15:0] w, input bit lc);
    logic [7:0] c;
    for (int i = 3; i >= 0; i--) begin
      c = hx(w[4*i+:4]);
      if (lc && c > 8'h39) c = c + 8'h20;
      send(c);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    rxq.delete();
    send_word(a, 1'b1);
    send(CH_WRITE);
    send_word(v, 1'b0);
    repeat (30) @(posedge REF_CLK_I);
    cmp_char(8'(rxq.size()), 8'h00);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    int n;
    rxq.delete();
    send_word(a, 1'b0);
    send(CH_READ);
    n = 0;
    while (rxq.size() < 4 && n < 400) begin
      @(posedge REF_CLK_I);
      n++;
    end
    cmp_char(8'(rxq.size()), 8'h04);
    for (int i = 0; i < 4 && i < rxq.size(); i++) cmp_char(rxq[i], hx(e[12-4*i+:4]));
    repeat (4) @(posedge REF_CLK_I);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed = 12;
    repeat (20) @(posedge REF_CLK_I);
    for (int i = 0; i < 8; i++) begin
      #10 RESET_I = 1'b1;
      RATE_SEL_I = 3'(i);
      repeat (2) @(posedge REF_CLK_I);
      #10 RESET_I = 1'b0;
      RATE_SEL_I = ~3'(i);
      repeat (3) @(posedge REF_CLK_I);
      cmp_rate({code, div}, {3'(i), dv(3'(i))});
      cmp_rate({rcode, rdiv}, {1'b0, 2'(i), dv({1'b0, 2'(i)})});
    end
    rd(16'h0000, 16'h0000);
    cmp_led(led, 4'h0);
    wr(16'h0000, 16'h5555);
    cmp_led(led, 4'h5);
    wr(16'h0001, 16'hAAAA);
    cmp_led(led, 4'hA);
    for (int k = 0; k < 16; k++) begin
      d[k] = 16'($random(seed));
      wr(16'(k), d[k]);
      cmp_led(led, d[k][3:0]);
    end
    wr(16'h0010, 16'h1234);
    cmp_led(led, d[15][3:0]);
    rd(16'h0010, 16'h0000);
    for (int k = 0; k < 16; k++) rd(16'(k), d[k]);
    send(8'h31);
    send(8'h47);
    wr(16'h0003, 16'hBEEF);
    rd(16'h0003, 16'hBEEF);
    send_word(16'h0004, 1'b0);
    send(8'h3F);
    rd(16'h0004, d[4]);
    send_word(16'h0005, 1'b0);
    send(CH_WRITE);
    send(8'h31);
    send(8'h5A);
    rd(16'h0005, d[5]);
    #10 RESET_I = 1'b1;
    repeat (2) @(posedge REF_CLK_I);
    #10 RESET_I = 1'b0;
    rd(16'h0001, 16'h0000);
    cmp_led(led, 4'h0);
    wrap_up();
  end
  initial begin
    #(100 * 40000);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
